// ===== cmpev_pkg.sv
// Purpose: Shared constants and carrier types for the comparator event and reference control block
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: Printed offsets are not word aligned, so they are kept as indices and the byte address is index times four

package cmpev_pkg;

	// ----------------------------------------
	// Register indices and bus address width
	// ----------------------------------------
	localparam logic [11:0] IDX_LADDER_CTRL = 12'hf53;
	localparam logic [11:0] IDX_CMP_CTRL1 = 12'hfd2;
	localparam logic [11:0] IDX_CMP_CTRL2 = 12'hfd1;
	localparam logic [11:0] IDX_OUT_STATUS = 12'hf70;
	localparam logic [11:0] IDX_CORE_IRQ = 12'hff2;
	localparam logic [11:0] IDX_PERIPH_FLAGS2 = 12'hfa1;
	localparam logic [11:0] IDX_PERIPH_EN2 = 12'hfa0;
	localparam logic [11:0] IDX_PERIPH_PRIO2 = 12'hfa2;
	localparam logic [11:0] IDX_SLEEP_CTRL = 12'hf00;
	localparam int ADDR_W = 14;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CC_ON = 7;
	localparam int CC_OUT_EN = 6;
	localparam int CC_INVERT = 5;
	localparam int CC_EDGE_HI = 4;
	localparam int CC_EDGE_LO = 3;
	localparam int CC_REF_SEL = 2;
	localparam int LC_POWER = 7;
	localparam int LC_PIN_DRIVE = 6;
	localparam int LC_RANGE = 5;
	localparam int LC_CODE_HI = 3;
	localparam int IC_GLOBAL = 7;
	localparam int IC_PERIPH = 6;
	localparam int PF_CMP1 = 5;
	localparam int PF_CMP2 = 6;
	localparam int NUM_CMP = 2;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_CMP_CTRL = 8'h1f;
	localparam logic [7:0] RST_LADDER_CTRL = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] FLAG_MASK = 8'h60;

	// ----------------------------------------
	// Event edge select codes
	// ----------------------------------------
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_ANY = 2'h3;

	// ----------------------------------------
	// AXI responses
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic on;
		logic outEn;
		logic invert;
		logic [1:0] edgeSel;
		logic refSel;
		logic [1:0] channel;
	} cmpev_cmp_ctrl_type;

	typedef struct packed {
		logic powerOn;
		logic pinDrive;
		logic rangeSel;
		logic reserved;
		logic [3:0] levelCode;
	} cmpev_ladder_ctrl_type;

endpackage : cmpev_pkg

// ===== cmpev_edge_detect.sv
// Purpose: Synchronise one raw comparator result, apply inversion and raise an event pulse
// Assumes: Raw result is asynchronous to clk
// Notes: Sync stage one feeds only sync stage two

`timescale 1ns/100ps

module cmpev_edge_detect
	import cmpev_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic rawResult,
	input wire logic enable,
	input wire logic invert,
	input wire logic [1:0] edgeSel,
	output logic result,
	output logic eventPulse
);

	logic sync1_ff, sync2_ff, prev_ff;
	logic nxt_sync1, nxt_sync2, nxt_prev;
	logic adjusted;
	logic rise, fall;

	always_comb begin
		nxt_sync1 = rawResult;
		nxt_sync2 = sync1_ff;
		// A disabled comparator reads as its invert bit: low, or high when inverted
		adjusted = (sync2_ff & enable) ^ invert;
		nxt_prev = adjusted;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
			prev_ff <= nxt_prev;
		end
	end

	always_comb begin
		rise = adjusted & ~prev_ff;
		fall = ~adjusted & prev_ff;
		case (edgeSel)
			EDGE_RISE: eventPulse = rise;
			EDGE_FALL: eventPulse = fall;
			EDGE_ANY: eventPulse = rise | fall;
			default: eventPulse = 1'b0;
		endcase
	end

	assign result = prev_ff;

endmodule : cmpev_edge_detect

// ===== cmpev_axil_slave.sv
// Purpose: AXI4-Lite slave front end turning bus transfers into single-cycle register strobes
// Assumes: One write and one read under way at a time
// Notes: Write answer three cycles after both channels are taken, two when byte lane 0 is off; read answer one cycle after address

`timescale 1ns/100ps

module cmpev_axil_slave
	import cmpev_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wrStrobe,
	output logic [11:0] wrIndex,
	output logic [7:0] wrData,
	input wire logic wrHit,
	output logic [11:0] rdIndex,
	input wire logic [7:0] rdData,
	input wire logic rdHit
);

	logic awHeld_ff, wHeld_ff, bvalid_ff, rvalid_ff, wrStrobe_ff;
	logic nxt_awHeld, nxt_wHeld, nxt_bvalid, nxt_rvalid, nxt_wrStrobe;
	logic [11:0] awIdx_ff, nxt_awIdx;
	logic [7:0] wData_ff, nxt_wData;
	logic wLane_ff, nxt_wLane;
	logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata;

	// ----------------------------------------
	// Write path
	// ----------------------------------------
	always_comb begin
		s_axi_awready = ~awHeld_ff & ~bvalid_ff & ~wrStrobe_ff;
		s_axi_wready = ~wHeld_ff & ~bvalid_ff & ~wrStrobe_ff;
		nxt_awHeld = awHeld_ff;
		nxt_wHeld = wHeld_ff;
		nxt_awIdx = awIdx_ff;
		nxt_wData = wData_ff;
		nxt_wLane = wLane_ff;
		nxt_wrStrobe = 1'b0;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_awHeld = 1'b1;
			nxt_awIdx = s_axi_awaddr[ADDR_W-1:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_wHeld = 1'b1;
			nxt_wData = s_axi_wdata[7:0];
			nxt_wLane = s_axi_wstrb[0];
		end
		if (awHeld_ff && wHeld_ff) begin
			nxt_awHeld = 1'b0;
			nxt_wHeld = 1'b0;
			nxt_wrStrobe = wLane_ff;
		end
		if (wrStrobe_ff || (awHeld_ff && wHeld_ff && !wLane_ff)) begin
			nxt_bvalid = 1'b1;
		end
		if (wrStrobe_ff) begin
			nxt_bresp = wrHit ? RESP_OKAY : RESP_SLVERR;
		end else if (awHeld_ff && wHeld_ff && !wLane_ff) begin
			nxt_bresp = RESP_OKAY;
		end
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			awIdx_ff <= 12'h000;
			wData_ff <= 8'h00;
			wLane_ff <= 1'b0;
			wrStrobe_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else begin
			awHeld_ff <= nxt_awHeld;
			wHeld_ff <= nxt_wHeld;
			awIdx_ff <= nxt_awIdx;
			wData_ff <= nxt_wData;
			wLane_ff <= nxt_wLane;
			wrStrobe_ff <= nxt_wrStrobe;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
		end
	end

	assign wrStrobe = wrStrobe_ff;
	assign wrIndex = awIdx_ff;
	assign wrData = wData_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	assign rdIndex = s_axi_araddr[ADDR_W-1:2];

	always_comb begin
		s_axi_arready = ~rvalid_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rdata = {24'h000000, rdData};
			nxt_rresp = rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= RESP_OKAY;
		end else begin
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

endmodule : cmpev_axil_slave

// ===== cmpev_top.sv
// Purpose: Comparator event flags, interrupt gating and reference ladder control behind AXI4-Lite
// Assumes: Raw comparator results arrive asynchronously; sleep is signalled by the core
// Notes: Analog parts sit outside; this block drives their control levels
//
// The AXI4-Lite slave port was decided locally.

`timescale 1ns/100ps

module cmpev_top
	import cmpev_pkg::*;
#(
	parameter int NCMP = NUM_CMP
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NCMP-1:0] comparatorRaw,
	input wire logic sleepActive,
	input wire logic pinDirectionIn,
	output logic [NCMP-1:0] comparatorOn,
	output logic [NCMP-1:0] comparatorPinOut,
	output logic [NCMP-1:0] comparatorPinOutEn,
	output logic [NCMP-1:0] comparatorRefSel,
	output logic [2*NCMP-1:0] comparatorChannel,
	output logic ladderPowerOn,
	output logic ladderRangeSel,
	output logic [3:0] ladderLevelCode,
	output logic ladderPinDrive,
	output logic refPinInputEn,
	output logic [7:0] ladderTapNum,
	output logic [7:0] ladderTapDen,
	output logic irqRequest,
	output logic wakeRequest,
	output logic [NCMP-1:0] comparatorEventFlag,
	output logic [7:0] comparatorOutputStatus
);

	// ----------------------------------------
	// Bus front end
	// ----------------------------------------
	logic wrStrobe, wrHit, rdHit;
	logic [11:0] wrIndex, rdIndex;
	logic [7:0] wrData, rdData;

	cmpev_axil_slave u_slave (
		.clk(clk),
		.rst(rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wrStrobe(wrStrobe),
		.wrIndex(wrIndex),
		.wrData(wrData),
		.wrHit(wrHit),
		.rdIndex(rdIndex),
		.rdData(rdData),
		.rdHit(rdHit)
	);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	cmpev_cmp_ctrl_type cmpCtrl_ff [NCMP];
	cmpev_cmp_ctrl_type nxt_cmpCtrl [NCMP];
	cmpev_ladder_ctrl_type ladder_ff, nxt_ladder;
	logic [7:0] coreIrq_ff, nxt_coreIrq;
	logic [7:0] periphFlags_ff, nxt_periphFlags;
	logic [7:0] periphEn_ff, nxt_periphEn;
	logic [7:0] periphPrio_ff, nxt_periphPrio;
	logic [NCMP-1:0] result, eventPulse;

	// Flag bit for each comparator
	function automatic int flagBit(input int idx);
		flagBit = PF_CMP1 + idx;
	endfunction : flagBit

	// ----------------------------------------
	// Comparator channels
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < NCMP; g++) begin : g_cmp
			cmpev_edge_detect u_edge (
				.clk(clk),
				.rst(rst),
				.rawResult(comparatorRaw[g]),
				.enable(cmpCtrl_ff[g].on),
				.invert(cmpCtrl_ff[g].invert),
				.edgeSel(cmpCtrl_ff[g].edgeSel),
				.result(result[g]),
				.eventPulse(eventPulse[g])
			);
			// Keeps operating regardless of sleep; no sleep gating here
			assign comparatorOn[g] = cmpCtrl_ff[g].on;
			assign comparatorPinOut[g] = result[g];
			assign comparatorPinOutEn[g] = ~cmpCtrl_ff[g].outEn;
			assign comparatorRefSel[g] = cmpCtrl_ff[g].refSel;
			assign comparatorChannel[2*g +: 2] = cmpCtrl_ff[g].channel;
			assign comparatorEventFlag[g] = periphFlags_ff[flagBit(g)];
		end
	endgenerate

	// ----------------------------------------
	// Register writes and flag updates
	// ----------------------------------------
	function automatic logic [11:0] cmpIndex(input int idx);
		cmpIndex = (idx == 0) ? IDX_CMP_CTRL1 : IDX_CMP_CTRL2;
	endfunction : cmpIndex

	always_comb begin
		for (int i = 0; i < NCMP; i++) begin
			nxt_cmpCtrl[i] = cmpCtrl_ff[i];
		end
		nxt_ladder = ladder_ff;
		nxt_coreIrq = coreIrq_ff;
		nxt_periphFlags = periphFlags_ff;
		nxt_periphEn = periphEn_ff;
		nxt_periphPrio = periphPrio_ff;
		wrHit = 1'b0;
		// Sleep never touches control state
		if (wrStrobe) begin
			if (wrIndex == IDX_LADDER_CTRL) begin
				nxt_ladder = wrData;
				wrHit = 1'b1;
			end else if (wrIndex == IDX_CORE_IRQ) begin
				nxt_coreIrq = wrData;
				wrHit = 1'b1;
			end else if (wrIndex == IDX_PERIPH_FLAGS2) begin
				// Write zero clears, write one sets
				nxt_periphFlags = wrData;
				wrHit = 1'b1;
			end else if (wrIndex == IDX_PERIPH_EN2) begin
				nxt_periphEn = wrData;
				wrHit = 1'b1;
			end else if (wrIndex == IDX_PERIPH_PRIO2) begin
				nxt_periphPrio = wrData;
				wrHit = 1'b1;
			end else if (wrIndex == IDX_OUT_STATUS) begin
				// Read-only: write accepted and dropped
				wrHit = 1'b1;
			end
			for (int i = 0; i < NCMP; i++) begin
				if (wrIndex == cmpIndex(i)) begin
					nxt_cmpCtrl[i] = wrData;
					wrHit = 1'b1;
				end
			end
		end
		// Hardware set wins over a software clear in the same cycle
		for (int i = 0; i < NCMP; i++) begin
			if (eventPulse[i]) begin
				nxt_periphFlags[flagBit(i)] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NCMP; i++) begin
				cmpCtrl_ff[i] <= RST_CMP_CTRL;
			end
			ladder_ff <= RST_LADDER_CTRL;
			coreIrq_ff <= RST_ZERO;
			periphFlags_ff <= RST_ZERO;
			periphEn_ff <= RST_ZERO;
			periphPrio_ff <= RST_ZERO;
		end else begin
			for (int i = 0; i < NCMP; i++) begin
				cmpCtrl_ff[i] <= nxt_cmpCtrl[i];
			end
			ladder_ff <= nxt_ladder;
			coreIrq_ff <= nxt_coreIrq;
			periphFlags_ff <= nxt_periphFlags;
			periphEn_ff <= nxt_periphEn;
			periphPrio_ff <= nxt_periphPrio;
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	always_comb begin
		rdData = 8'h00;
		rdHit = 1'b1;
		if (rdIndex == IDX_LADDER_CTRL) begin
			rdData = ladder_ff;
		end else if (rdIndex == IDX_CORE_IRQ) begin
			rdData = coreIrq_ff;
		end else if (rdIndex == IDX_PERIPH_FLAGS2) begin
			rdData = periphFlags_ff;
		end else if (rdIndex == IDX_PERIPH_EN2) begin
			rdData = periphEn_ff;
		end else if (rdIndex == IDX_PERIPH_PRIO2) begin
			rdData = periphPrio_ff;
		end else if (rdIndex == IDX_OUT_STATUS) begin
			rdData = comparatorOutputStatus;
		end else if (rdIndex == IDX_CMP_CTRL1) begin
			rdData = cmpCtrl_ff[0];
		end else if (rdIndex == IDX_CMP_CTRL2) begin
			rdData = cmpCtrl_ff[NCMP-1];
		end else begin
			rdHit = 1'b0;
		end
	end

	always_comb begin
		comparatorOutputStatus = 8'h00;
		comparatorOutputStatus[NCMP-1:0] = result;
	end

	// ----------------------------------------
	// Interrupt gating and wake
	// ----------------------------------------
	logic [NCMP-1:0] enabledFlags;

	always_comb begin
		for (int i = 0; i < NCMP; i++) begin
			enabledFlags[i] = periphFlags_ff[flagBit(i)] & periphEn_ff[flagBit(i)];
		end
		// Flags still set above whatever the enables say
		irqRequest = (|enabledFlags) & coreIrq_ff[IC_PERIPH] & coreIrq_ff[IC_GLOBAL];
		// Wake ignores the global enable, as a core usually resumes without vectoring
		wakeRequest = sleepActive & (|enabledFlags) & coreIrq_ff[IC_PERIPH];
	end

	// ----------------------------------------
	// Reference ladder
	// ----------------------------------------
	// Ladder runs on its own bit only, comparators play no part
	assign ladderPowerOn = ladder_ff.powerOn;
	assign ladderRangeSel = ladder_ff.rangeSel;
	assign ladderLevelCode = ladder_ff.levelCode;
	assign ladderPinDrive = ladder_ff.pinDrive;
	// Pin drive forces the shared pin off its digital direction
	assign refPinInputEn = pinDirectionIn & ~ladder_ff.pinDrive;

	// Reference as a fraction of supply: num/den
	always_comb begin
		if (!ladder_ff.powerOn) begin
			ladderTapNum = 8'h00;
			ladderTapDen = 8'h01;
		end else if (ladder_ff.rangeSel) begin
			ladderTapNum = {4'h0, ladder_ff.levelCode};
			ladderTapDen = 8'h18;
		end else begin
			ladderTapNum = 8'h08 + {4'h0, ladder_ff.levelCode};
			ladderTapDen = 8'h20;
		end
	end

endmodule : cmpev_top

// ===== cmpev_assertions.sv
// Purpose: Port-level checks of the comparator event and ladder block
// Assumes: Only the top-level ports are visible
// Notes: Register contents are judged by the bench, not here
`timescale 1ns/100ps

module cmpev_assertions
	import cmpev_pkg::*;
#(
	parameter int NCMP = NUM_CMP
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic sleepActive,
	input wire logic pinDirectionIn,
	input wire logic [NCMP-1:0] comparatorPinOut,
	input wire logic ladderPowerOn,
	input wire logic ladderRangeSel,
	input wire logic [3:0] ladderLevelCode,
	input wire logic ladderPinDrive,
	input wire logic refPinInputEn,
	input wire logic [7:0] ladderTapNum,
	input wire logic [7:0] ladderTapDen,
	input wire logic irqRequest,
	input wire logic wakeRequest,
	input wire logic [NCMP-1:0] comparatorEventFlag,
	input wire logic [7:0] comparatorOutputStatus
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	irq_needs_flag_a: assert property (irqRequest |-> |comparatorEventFlag)
		else $error("request raised with no flag set");
	wake_needs_sleep_a: assert property (wakeRequest |-> sleepActive && |comparatorEventFlag)
		else $error("wake raised outside sleep or without flag");
	pin_override_a: assert property (refPinInputEn == (pinDirectionIn && !ladderPinDrive))
		else $error("pin drive does not override direction");
	fine_range_a: assert property (ladderPowerOn && ladderRangeSel |->
		ladderTapNum == {4'h0, ladderLevelCode} && ladderTapDen == 8'h18) else $error("fine range ratio wrong");
	coarse_range_a: assert property (ladderPowerOn && !ladderRangeSel |->
		ladderTapNum == 8'h08 + {4'h0, ladderLevelCode} && ladderTapDen == 8'h20) else $error("coarse ratio wrong");
	ladder_off_a: assert property (!ladderPowerOn |-> ladderTapNum == 8'h00 && ladderTapDen == 8'h01)
		else $error("ladder output while powered down");
	flag_hold_a: assert property ($fell(comparatorEventFlag[0]) |-> $rose(s_axi_bvalid))
		else $error("flag cleared without a write");
	flag_cause_a: assert property ($rose(comparatorEventFlag[0]) |->
		$changed(comparatorOutputStatus[0]) || $rose(s_axi_bvalid)) else $error("flag set without cause");
	status_shape_a: assert property (comparatorOutputStatus[7:NCMP] == '0 &&
		comparatorPinOut == comparatorOutputStatus[NCMP-1:0]) else $error("status bits malformed");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");

	cover property ($rose(comparatorEventFlag[0]));
	cover property ($rose(wakeRequest));
	cover property (irqRequest);
endmodule : cmpev_assertions

bind cmpev_top cmpev_assertions #(.NCMP(NCMP)) chkr (.clk(clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .sleepActive(sleepActive),
	.pinDirectionIn(pinDirectionIn), .comparatorPinOut(comparatorPinOut), .ladderPowerOn(ladderPowerOn),
	.ladderRangeSel(ladderRangeSel), .ladderLevelCode(ladderLevelCode), .ladderPinDrive(ladderPinDrive),
	.refPinInputEn(refPinInputEn), .ladderTapNum(ladderTapNum), .ladderTapDen(ladderTapDen),
	.irqRequest(irqRequest), .wakeRequest(wakeRequest), .comparatorEventFlag(comparatorEventFlag),
	.comparatorOutputStatus(comparatorOutputStatus));

// ===== cmpev_analog_model.sv
// Purpose: Behavioural comparators and sleeping core around the block
// Assumes: Bench sets which input is higher per comparator
// Notes: A powered-down comparator shows a wrong level, so gating inside is exercised
`timescale 1ns/100ps

module cmpev_analog_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] plusAbove,
	input wire logic sleepReq,
	input wire logic [1:0] comparatorOn,
	input wire logic wakeRequest,
	output logic [1:0] comparatorRaw,
	output logic sleepActive
);
	assign comparatorRaw = (comparatorOn & plusAbove) | (~comparatorOn & ~plusAbove);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sleepActive <= 1'b0;
		end else if (sleepReq) begin
			sleepActive <= 1'b1;
		end else if (wakeRequest) begin
			sleepActive <= 1'b0;
		end
	end
endmodule : cmpev_analog_model

// ===== test_comparator_event_and_reference_ctrl.sv
// Purpose: Register-level tests of the comparator event and ladder block
// Assumes: Bus tasks hold each request until its ready is seen
// Notes: Only comparator one runs the edge table; two is set by software
`timescale 1ns/100ps

module test_comparator_event_and_reference_ctrl;
	import cmpev_pkg::*;
	logic clk = 1'b0, rst = 1'b1, sleepReq = 1'b0, pinDirectionIn = 1'b1;
	logic [1:0] plusAbove = 2'b00, comparatorRaw, comparatorOn;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, comparatorEventFlag;
	logic sleepActive, ladderPowerOn, ladderRangeSel, ladderPinDrive, refPinInputEn, irqRequest, wakeRequest;
	logic [3:0] ladderLevelCode;
	logic [7:0] ladderTapNum, ladderTapDen, comparatorOutputStatus, v, num, den;
	logic [7:0] ladVal [3] = '{8'hab, 8'hd7, 8'h3f};
	logic inv, fr, ff;
	logic [1:0] sel;
	int fails = 0, cmpCount = 0;

	always #2 clk = ~clk;

	cmpev_analog_model partner (.clk(clk), .rst(rst), .plusAbove(plusAbove), .sleepReq(sleepReq),
		.comparatorOn(comparatorOn), .wakeRequest(wakeRequest), .comparatorRaw(comparatorRaw),
		.sleepActive(sleepActive));

	cmpev_top DUT (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.comparatorRaw(comparatorRaw), .sleepActive(sleepActive), .pinDirectionIn(pinDirectionIn),
		.comparatorOn(comparatorOn), .comparatorPinOut(), .comparatorPinOutEn(), .comparatorRefSel(),
		.comparatorChannel(), .ladderPowerOn(ladderPowerOn), .ladderRangeSel(ladderRangeSel),
		.ladderLevelCode(ladderLevelCode), .ladderPinDrive(ladderPinDrive), .refPinInputEn(refPinInputEn),
		.ladderTapNum(ladderTapNum), .ladderTapDen(ladderTapDen), .irqRequest(irqRequest),
		.wakeRequest(wakeRequest), .comparatorEventFlag(comparatorEventFlag),
		.comparatorOutputStatus(comparatorOutputStatus));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic conclude;
		$display("mismatches=%0d comparisons=%0d", fails, cmpCount);
		if (fails == 0 && cmpCount > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude

	task automatic ticks(input int k);
		repeat (k) @(posedge clk);
	endtask : ticks

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic axiWrite(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] expResp);
		int n;
		logic ta, tw, tb;
		logic [1:0] r;
		@(posedge clk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (n == 50) begin
			fails++;
			conclude();
		end
		chk({30'h0, r}, {30'h0, expResp});
	endtask : axiWrite

	task automatic axiRead(input logic [11:0] idx, input logic [31:0] exp, input logic [1:0] expResp);
		int n;
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) begin
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (n == 50) begin
			fails++;
			conclude();
		end
		chk(d, exp);
		chk({30'h0, r}, {30'h0, expResp});
	endtask : axiRead

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		ticks(2);
		rst <= 1'b0;
		axiRead(IDX_LADDER_CTRL, 32'h0, RESP_OKAY);
		axiRead(IDX_CMP_CTRL1, 32'h1f, RESP_OKAY);
		axiRead(12'h123, 32'h0, RESP_SLVERR);
		axiWrite(12'h123, 8'h55, RESP_SLVERR);
		axiWrite(IDX_OUT_STATUS, 8'hff, RESP_OKAY);
		axiRead(IDX_OUT_STATUS, 32'h0, RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			v = ladVal[i];
			num = !v[7] ? 8'h00 : v[5] ? {4'h0, v[3:0]} : 8'h08 + {4'h0, v[3:0]};
			den = !v[7] ? 8'h01 : v[5] ? 8'h18 : 8'h20;
			axiWrite(IDX_LADDER_CTRL, v, RESP_OKAY);
			axiRead(IDX_LADDER_CTRL, {24'h0, v}, RESP_OKAY);
			chk({ladderTapDen, ladderTapNum}, {den, num});
			chk({31'h0, refPinInputEn}, {31'h0, !v[6]});
		end
		axiWrite(IDX_LADDER_CTRL, 8'hab, RESP_OKAY);
		axiWrite(IDX_CORE_IRQ, 8'hc0, RESP_OKAY);
		axiWrite(IDX_PERIPH_EN2, 8'h60, RESP_OKAY);
		for (int m = 0; m < 8; m++) begin
			inv = m[2];
			sel = m[1:0];
			fr = sel == EDGE_ANY || sel == (inv ? EDGE_FALL : EDGE_RISE);
			ff = sel == EDGE_ANY || sel == (inv ? EDGE_RISE : EDGE_FALL);
			plusAbove <= 2'b00;
			axiWrite(IDX_CMP_CTRL1, {2'b10, inv, sel, 3'b000}, RESP_OKAY);
			chk({30'h0, comparatorOn}, 32'h1);
			ticks(6);
			axiWrite(IDX_PERIPH_FLAGS2, 8'h00, RESP_OKAY);
			chk({24'h0, comparatorOutputStatus}, {31'h0, inv});
			plusAbove <= 2'b01;
			ticks(6);
			axiRead(IDX_PERIPH_FLAGS2, {26'h0, fr, 5'h0}, RESP_OKAY);
			chk({31'h0, irqRequest}, {31'h0, fr});
			axiWrite(IDX_PERIPH_FLAGS2, 8'h00, RESP_OKAY);
			plusAbove <= 2'b00;
			ticks(6);
			axiRead(IDX_PERIPH_FLAGS2, {26'h0, ff, 5'h0}, RESP_OKAY);
		end
		axiWrite(IDX_PERIPH_FLAGS2, 8'h40, RESP_OKAY);
		axiRead(IDX_PERIPH_FLAGS2, 32'h40, RESP_OKAY);
		chk({31'h0, irqRequest}, 32'h1);
		axiWrite(IDX_CORE_IRQ, 8'h40, RESP_OKAY);
		ticks(20);
		chk({31'h0, irqRequest}, 32'h0);
		axiRead(IDX_PERIPH_FLAGS2, 32'h40, RESP_OKAY);
		// Only comparator one may wake the core
		axiWrite(IDX_PERIPH_EN2, 8'h20, RESP_OKAY);
		sleepReq <= 1'b1;
		ticks(1);
		sleepReq <= 1'b0;
		ticks(6);
		chk({31'h0, sleepActive}, 32'h1);
		plusAbove <= 2'b01;
		ticks(8);
		chk({31'h0, sleepActive}, 32'h0);
		axiRead(IDX_CMP_CTRL1, 32'hb8, RESP_OKAY);
		axiRead(IDX_LADDER_CTRL, 32'hab, RESP_OKAY);
		rst <= 1'b1;
		ticks(2);
		rst <= 1'b0;
		axiRead(IDX_CMP_CTRL1, 32'h1f, RESP_OKAY);
		axiRead(IDX_CMP_CTRL2, 32'h1f, RESP_OKAY);
		axiRead(IDX_LADDER_CTRL, 32'h0, RESP_OKAY);
		chk({29'h0, comparatorOn, ladderPowerOn}, 32'h0);
		conclude();
	end
endmodule : test_comparator_event_and_reference_ctrl
